// File: src/ultc_pkg.sv
package ultc_pkg;

	// register index map (no offsets printed; chosen locally)
	localparam logic [2:0] ADDR_RX_IRQ_LEVEL  = 3'h0;
	localparam logic [2:0] ADDR_FLOW_UPPER    = 3'h1;
	localparam logic [2:0] ADDR_FLOW_LOWER    = 3'h2;
	localparam logic [2:0] ADDR_CLK_FRACTION  = 3'h3;
	localparam logic [2:0] ADDR_OVERSAMPLE    = 3'h4;
	localparam logic [2:0] ADDR_TURNAROUND    = 3'h5;
	localparam logic [2:0] ADDR_FEATURE_TWO   = 3'h6;
	localparam logic [2:0] ADDR_STATUS        = 3'h7;

	// reset values
	localparam logic [7:0] RST_LEVEL          = 8'h00;
	localparam logic [3:0] RST_FRACTION       = 4'h0;
	localparam logic [1:0] RST_OVERSAMPLE     = 2'h0;
	localparam logic [7:0] RST_TURNAROUND     = 8'h00;
	localparam logic [7:0] RST_FEATURE_TWO    = 8'h00;

	// field positions and widths
	localparam int FRACTION_W                 = 4;
	localparam int OVERSAMPLE_W               = 2;
	localparam int FT_NINE_BIT_POS            = 0;
	localparam int FT_DTR_SELECT_POS          = 3;
	localparam int FT_TX_CONTROL_POS          = 4;
	localparam int FT_INVERT_POS              = 5;

	// oversampling codes
	localparam logic [1:0] OVS_16X            = 2'h0;
	localparam logic [1:0] OVS_8X             = 2'h1;
	localparam logic [1:0] OVS_4X             = 2'h2;
	localparam logic [4:0] OVS_RATE_16        = 5'h10;
	localparam logic [4:0] OVS_RATE_8         = 5'h08;
	localparam logic [4:0] OVS_RATE_4         = 5'h04;

	// fraction granularity in sixteenths
	localparam logic [4:0] FRACTION_ONE       = 5'h10;

	typedef struct packed {
		logic [7:0] rx_irq_level;
		logic [7:0] flow_upper;
		logic [7:0] flow_lower;
	} ultc_levels_s;

	typedef struct packed {
		logic       write;
		logic       read;
		logic [2:0] addr;
		logic [7:0] wdata;
	} ultc_bus_s;

endpackage : ultc_pkg

// File: src/ultc_turnaround.sv
// counts bit times down after the last transmitted bit
module ultc_turnaround #(
	parameter int CNT_W = 8
) (
	input  wire logic             clk_sys,
	input  wire logic             reset_n,
	input  wire logic             start,
	input  wire logic             bit_tick,
	input  wire logic [CNT_W-1:0] delay,
	output logic                  busy_q,
	output logic                  done
);

	logic [CNT_W-1:0] count_q;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			count_q <= '0;
			busy_q  <= 1'b0;
		end
		else if (start)
		begin
			count_q <= delay;
			busy_q  <= 1'b1;
		end
		else if (busy_q && (count_q == '0))
			busy_q <= 1'b0;
		else if (busy_q && bit_tick)
			count_q <= count_q - 1'b1;
	end

	// zero reached: one-cycle pulse
	assign done = busy_q && (count_q == '0) && !start;

	a_done_at_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
		done |=> !busy_q) else $error("turnaround busy after done");

	a_load_delay: assert property (@(posedge clk_sys) disable iff (!reset_n)
		start |=> busy_q && count_q == $past(delay)) else $error("delay not loaded");

	a_step_per_tick: assert property (@(posedge clk_sys) disable iff (!reset_n)
		busy_q && !start && bit_tick && count_q != '0 |=> count_q == $past(count_q) - 1'b1)
		else $error("count did not step on bit tick");

	c_full_countdown: cover property (@(posedge clk_sys) disable iff (!reset_n)
		start ##[1:600] done);

endmodule : ultc_turnaround

// File: src/ultc_level_timing.sv
module ultc_level_timing (
	input  wire logic                clk_sys,
	input  wire logic                reset_n,
	input  wire ultc_pkg::ultc_bus_s bus,
	output logic [7:0]               rdata_q,
	input  wire logic                fifo_mode_128,
	input  wire logic [7:0]          fifo_ctrl_rx_level,
	input  wire logic                tx_active,
	input  wire logic                tx_last_bit_done,
	input  wire logic                bit_tick,
	input  wire logic                rts_modem_n,
	input  wire logic                dtr_modem_n,
	output ultc_pkg::ultc_levels_s   levels_q,
	output logic [7:0]               rx_trigger_bytes,
	output logic                     ref_clk_en,
	output logic [4:0]               oversample_rate,
	output logic                     rts_pin_n,
	output logic                     dtr_pin_n,
	output logic                     nine_bit_mode
);

	ultc_pkg::ultc_levels_s lvl_q;
	logic [7:0]             raw_irq_q;
	logic [7:0]             raw_upper_q;
	logic [7:0]             raw_lower_q;
	logic [3:0]             fraction_q;
	logic [1:0]             oversample_q;
	logic [7:0]             turnaround_q;
	logic [7:0]             feature_q;
	logic                   dir_tx_q;
	logic                   ta_busy;
	logic                   ta_done;
	logic [4:0]             frac_acc_q;
	logic [5:0]             frac_sum;
	logic                   dir_level;
	logic                   ctrl_on;
	logic                   ctrl_sel_dtr;

	// decoding 0..0x80 to byte counts 1..128
	function automatic logic [7:0] ultc_level_decode(input logic [7:0] code);
		logic [7:0] res;
		res = code;
		if (code == 8'h00)
			res = 8'h01;
		else if (code > 8'h80)
			res = 8'h80;
		return res;
	endfunction : ultc_level_decode

	// register writes
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			raw_irq_q    <= ultc_pkg::RST_LEVEL;
			raw_upper_q  <= ultc_pkg::RST_LEVEL;
			raw_lower_q  <= ultc_pkg::RST_LEVEL;
			fraction_q   <= ultc_pkg::RST_FRACTION;
			oversample_q <= ultc_pkg::RST_OVERSAMPLE;
			turnaround_q <= ultc_pkg::RST_TURNAROUND;
			feature_q    <= ultc_pkg::RST_FEATURE_TWO;
		end
		else if (bus.write)
		begin
			case (bus.addr)
				ultc_pkg::ADDR_RX_IRQ_LEVEL: raw_irq_q    <= bus.wdata;
				ultc_pkg::ADDR_FLOW_UPPER:   raw_upper_q  <= bus.wdata;
				ultc_pkg::ADDR_FLOW_LOWER:   raw_lower_q  <= bus.wdata;
				ultc_pkg::ADDR_CLK_FRACTION: fraction_q   <= bus.wdata[3:0];
				ultc_pkg::ADDR_OVERSAMPLE:   oversample_q <= bus.wdata[1:0];
				ultc_pkg::ADDR_TURNAROUND:   turnaround_q <= bus.wdata;
				ultc_pkg::ADDR_FEATURE_TWO:  feature_q    <= bus.wdata;
				default: ;
			endcase
		end
	end

	// decoded byte levels, registered
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			lvl_q <= '0;
		else
		begin
			lvl_q.rx_irq_level <= ultc_level_decode(raw_irq_q);
			lvl_q.flow_upper   <= ultc_level_decode(raw_upper_q);
			lvl_q.flow_lower   <= ultc_level_decode(raw_lower_q);
		end
	end
	assign levels_q = lvl_q;

	assign rx_trigger_bytes = fifo_mode_128 ? lvl_q.rx_irq_level : fifo_ctrl_rx_level;

	always_comb
	begin
		case (oversample_q)
			ultc_pkg::OVS_8X: oversample_rate = ultc_pkg::OVS_RATE_8;
			ultc_pkg::OVS_4X: oversample_rate = ultc_pkg::OVS_RATE_4;
			default:          oversample_rate = ultc_pkg::OVS_RATE_16;
		endcase
	end

	assign frac_sum   = {1'b0, frac_acc_q} + {2'b00, fraction_q};
	assign ref_clk_en = (fraction_q == '0) || (frac_sum < 6'(ultc_pkg::FRACTION_ONE));
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			frac_acc_q <= '0;
		else if (fraction_q == '0)
			frac_acc_q <= '0;
		else if (frac_sum >= 6'(ultc_pkg::FRACTION_ONE))
			frac_acc_q <= 5'(frac_sum - 6'(ultc_pkg::FRACTION_ONE));
		else
			frac_acc_q <= frac_sum[4:0];
	end

	assign nine_bit_mode = feature_q[ultc_pkg::FT_NINE_BIT_POS];
	assign ctrl_on       = nine_bit_mode && feature_q[ultc_pkg::FT_TX_CONTROL_POS];
	assign ctrl_sel_dtr  = feature_q[ultc_pkg::FT_DTR_SELECT_POS];

	ultc_turnaround #(
		.CNT_W (8)
	) u_turnaround (
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.start    (ctrl_on && tx_last_bit_done),
		.bit_tick (bit_tick),
		.delay    (turnaround_q),
		.busy_q   (ta_busy),
		.done     (ta_done)
	);

	// direction: high while sending, low once turned around
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			dir_tx_q <= 1'b0;
		else if (!ctrl_on)
			dir_tx_q <= 1'b0;
		else if (tx_active)
			dir_tx_q <= 1'b1;
		else if (ta_done)
			dir_tx_q <= 1'b0;
	end

	// receive level is logic 0 unless inverted
	assign dir_level = feature_q[ultc_pkg::FT_INVERT_POS] ? ~dir_tx_q : dir_tx_q;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rts_pin_n <= 1'b1;
			dtr_pin_n <= 1'b1;
		end
		else
		begin
			rts_pin_n <= (ctrl_on && !ctrl_sel_dtr) ? dir_level : rts_modem_n;
			dtr_pin_n <= (ctrl_on && ctrl_sel_dtr) ? dir_level : dtr_modem_n;
		end
	end

	// register readback; reserved read zero
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			rdata_q <= '0;
		else if (bus.read)
		begin
			case (bus.addr)
				ultc_pkg::ADDR_RX_IRQ_LEVEL: rdata_q <= raw_irq_q;
				ultc_pkg::ADDR_FLOW_UPPER:   rdata_q <= raw_upper_q;
				ultc_pkg::ADDR_FLOW_LOWER:   rdata_q <= raw_lower_q;
				ultc_pkg::ADDR_CLK_FRACTION: rdata_q <= {4'h0, fraction_q};
				ultc_pkg::ADDR_OVERSAMPLE:   rdata_q <= {6'h00, oversample_q};
				ultc_pkg::ADDR_TURNAROUND:   rdata_q <= turnaround_q;
				ultc_pkg::ADDR_FEATURE_TWO:  rdata_q <= feature_q;
				ultc_pkg::ADDR_STATUS:       rdata_q <= {6'h00, ta_busy, dir_tx_q};
				default:                     rdata_q <= 8'h00;
			endcase
		end
	end

	// rule guards next to the level, clock and direction logic
	// zero code decode
	a_level_low_code: assert property (@(posedge clk_sys) disable iff (!reset_n)
		raw_irq_q == 8'h00 && $stable(raw_irq_q) |=> lvl_q.rx_irq_level == 8'h01)
		else $error("code zero not one byte");

	a_level_top_code: assert property (@(posedge clk_sys) disable iff (!reset_n)
		raw_irq_q == 8'h80 && $stable(raw_irq_q) |=> lvl_q.rx_irq_level == 8'h80)
		else $error("top code not 128 bytes");

	a_level_mode: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!fifo_mode_128 |-> rx_trigger_bytes == fifo_ctrl_rx_level)
		else $error("level used outside 128 mode");

	a_level_own: assert property (@(posedge clk_sys) disable iff (!reset_n)
		fifo_mode_128 |-> rx_trigger_bytes == lvl_q.rx_irq_level)
		else $error("own level not used in 128 mode");

	a_upper_max: assert property (@(posedge clk_sys) disable iff (!reset_n)
		raw_upper_q == 8'h80 && $stable(raw_upper_q) |=> lvl_q.flow_upper == 8'h80)
		else $error("upper top code not 128");

	a_lower_code: assert property (@(posedge clk_sys) disable iff (!reset_n)
		raw_lower_q == 8'h01 && $stable(raw_lower_q) |=> lvl_q.flow_lower == 8'h01)
		else $error("lower code one wrong");

	a_fraction_rd: assert property (@(posedge clk_sys) disable iff (!reset_n)
		bus.read && bus.addr == ultc_pkg::ADDR_CLK_FRACTION |=> rdata_q[7:4] == 4'h0)
		else $error("prescaler reserved bits nonzero");

	a_ovs_rate: assert property (@(posedge clk_sys) disable iff (!reset_n)
		oversample_q == ultc_pkg::OVS_4X |-> oversample_rate == ultc_pkg::OVS_RATE_4)
		else $error("4x code gives wrong rate");

	a_ovs_reserved: assert property (@(posedge clk_sys) disable iff (!reset_n)
		oversample_q == 2'h3 |-> oversample_rate == ultc_pkg::OVS_RATE_16)
		else $error("reserved code not 16x");

	a_dir_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
		dir_tx_q && ctrl_on && !ctrl_sel_dtr
		&& !feature_q[ultc_pkg::FT_INVERT_POS] |=> rts_pin_n == 1'b1)
		else $error("direction pin low while sending");

	a_turn_release: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ta_done && !tx_active && ctrl_on && !ctrl_sel_dtr
		&& !feature_q[ultc_pkg::FT_INVERT_POS]
		##1 ctrl_on && !ctrl_sel_dtr && !feature_q[ultc_pkg::FT_INVERT_POS]
		|=> rts_pin_n == 1'b0) else $error("direction pin not low after countdown");

	a_dtr_release: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ta_done && !tx_active && ctrl_on && ctrl_sel_dtr
		&& !feature_q[ultc_pkg::FT_INVERT_POS]
		##1 ctrl_on && ctrl_sel_dtr && !feature_q[ultc_pkg::FT_INVERT_POS]
		|=> dtr_pin_n == 1'b0) else $error("second pin not low after countdown");

	a_start_gate: assert property (@(posedge clk_sys) disable iff (!reset_n)
		tx_last_bit_done && !ctrl_on && !ta_busy |=> !ta_busy)
		else $error("countdown started without control enable");

	a_no_ctrl: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!ctrl_on |=> rts_pin_n == $past(rts_modem_n) && dtr_pin_n == $past(dtr_modem_n))
		else $error("pin driven without control enable");

	a_ref_undiv: assert property (@(posedge clk_sys) disable iff (!reset_n)
		fraction_q == 4'h0 |-> ref_clk_en) else $error("zero prescaler divides");

	// main scenarios reached
	c_turnaround: cover property (@(posedge clk_sys) disable iff (!reset_n)
		ctrl_on && tx_last_bit_done ##[1:300] ta_done);
	c_dtr_path: cover property (@(posedge clk_sys) disable iff (!reset_n)
		ctrl_on && ctrl_sel_dtr && ta_done);
	c_mode_32: cover property (@(posedge clk_sys) disable iff (!reset_n) !fifo_mode_128);

endmodule : ultc_level_timing

// File: test/ultc_xcvr_model.sv
// line transceiver: direction taken from the chosen pin
module ultc_xcvr_model (
	input  wire logic dtr_sel,
	input  wire logic rts_pin_n,
	input  wire logic dtr_pin_n,
	output logic      rx_dir
);
	timeunit 1ns;
	timeprecision 100ps;
	// direction from pin
	// receive while the chosen direction pin is low
	assign rx_dir = dtr_sel ? ~dtr_pin_n : ~rts_pin_n;
endmodule : ultc_xcvr_model

// File: test/tb_top.sv
// self-checking bench for the level and timing slice
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic                   clk_sys = 1'h0;
	logic                   reset_n = 1'h0;
	logic                   fifo_mode_128 = 1'h1;
	logic                   tx_last_bit_done = 1'h0;
	logic                   bit_tick = 1'h0;
	logic                   rts_modem_n = 1'h1;
	logic                   dtr_modem_n = 1'h1;
	logic                   tx_active = 1'h0;
	logic                   dtr_sel = 1'h0;
	logic                   ref_clk_en, rts_pin_n, dtr_pin_n, nine_bit_mode, rx_dir;
	logic [7:0]             fifo_ctrl_rx_level = 8'h20;
	logic [7:0]             rdata_q, rx_trigger_bytes, e;
	logic [4:0]             oversample_rate;
	ultc_pkg::ultc_bus_s    bus = '0;
	ultc_pkg::ultc_levels_s levels_q;
	int                     n_errors = 0;
	int                     n_tests = 0;
	int                     cnt;

	ultc_level_timing uut (.clk_sys(clk_sys), .reset_n(reset_n), .bus(bus),
		.rdata_q(rdata_q), .fifo_mode_128(fifo_mode_128),
		.fifo_ctrl_rx_level(fifo_ctrl_rx_level), .tx_active(tx_active),
		.tx_last_bit_done(tx_last_bit_done), .bit_tick(bit_tick),
		.rts_modem_n(rts_modem_n), .dtr_modem_n(dtr_modem_n), .levels_q(levels_q),
		.rx_trigger_bytes(rx_trigger_bytes), .ref_clk_en(ref_clk_en),
		.oversample_rate(oversample_rate), .rts_pin_n(rts_pin_n),
		.dtr_pin_n(dtr_pin_n), .nine_bit_mode(nine_bit_mode));
	ultc_xcvr_model far (.dtr_sel(dtr_sel), .rts_pin_n(rts_pin_n),
		.dtr_pin_n(dtr_pin_n), .rx_dir(rx_dir));

	// clock generator
	always #12.5 clk_sys = ~clk_sys;

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
		n_tests++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		bus = '{1'h1, 1'h0, a, d};
		@(negedge clk_sys);
		bus = '0;
		@(negedge clk_sys);
	endtask : wr

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		bus = '{1'h0, 1'h1, a, 8'h00};
		@(negedge clk_sys);
		bus = '0;
		d = rdata_q;
	endtask : rd

	task automatic tick(input int n);
		repeat (n)
		begin
			@(negedge clk_sys);
			bit_tick = 1'h1;
			@(negedge clk_sys);
			bit_tick = 1'h0;
		end
	endtask : tick

	task automatic last_bit;
		@(negedge clk_sys);
		tx_last_bit_done = 1'h1;
		@(negedge clk_sys);
		tx_last_bit_done = 1'h0;
	endtask : last_bit

	task automatic print_verdict;
		$display("tests %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict

	task automatic t_reset;
		for (int a = 0; a < 8; a++)
		begin
			rd(3'(a), e);
			chk(e, 8'h00, "reset value");
		end
		chk(levels_q.rx_irq_level, 8'h01, "reset level");
		$display("test reset done");
	endtask : t_reset

	task automatic t_levels;
		logic [7:0] codes [5] = '{8'h00, 8'h01, 8'h40, 8'h80, 8'hFF};
		logic [7:0] x;
		foreach (codes[i])
		begin
			x = codes[i] == 8'h00 ? 8'h01 : (codes[i] > 8'h80 ? 8'h80 : codes[i]);
			wr(ultc_pkg::ADDR_RX_IRQ_LEVEL, codes[i]);
			wr(ultc_pkg::ADDR_FLOW_UPPER, codes[i]);
			wr(ultc_pkg::ADDR_FLOW_LOWER, codes[i]);
			chk(levels_q.rx_irq_level, x, "rx level");
			chk(levels_q.flow_upper, x, "upper");
			chk(levels_q.flow_lower, x, "lower");
			chk(rx_trigger_bytes, x, "trigger 128");
			rd(ultc_pkg::ADDR_FLOW_LOWER, e);
			chk(e, codes[i], "readback");
		end
		fifo_mode_128 = 1'h0;
		@(negedge clk_sys);
		chk(rx_trigger_bytes, 8'h20, "trigger 32");
		fifo_mode_128 = 1'h1;
		$display("test levels done");
	endtask : t_levels

	task automatic t_clock;
		logic [4:0] rates [4] = '{5'h10, 5'h08, 5'h04, 5'h10};
		wr(ultc_pkg::ADDR_CLK_FRACTION, 8'hFF);
		rd(ultc_pkg::ADDR_CLK_FRACTION, e);
		chk(e, 8'h0F, "fraction reserved");
		wr(ultc_pkg::ADDR_OVERSAMPLE, 8'hFF);
		rd(ultc_pkg::ADDR_OVERSAMPLE, e);
		chk(e, 8'h03, "sample reserved");
		for (int c = 0; c < 4; c++)
		begin
			wr(ultc_pkg::ADDR_OVERSAMPLE, 8'(c));
			chk(8'(oversample_rate), 8'(rates[c]), "rate");
		end
		for (int f = 0; f < 9; f += 8)
		begin
			wr(ultc_pkg::ADDR_CLK_FRACTION, 8'(f));
			cnt = 0;
			repeat (32)
			begin
				@(negedge clk_sys);
				cnt += ref_clk_en === 1'h1;
			end
			chk(8'(f == 0 ? cnt == 32 : cnt > 0 && cnt < 32), 8'h01, "prescale");
		end
		// mid-run reset clears the prescaler and sampling fields
		reset_n = 1'h0;
		repeat (2) @(negedge clk_sys);
		reset_n = 1'h1;
		@(negedge clk_sys);
		rd(ultc_pkg::ADDR_CLK_FRACTION, e);
		chk(e, 8'h00, "fraction after reset");
		rd(ultc_pkg::ADDR_OVERSAMPLE, e);
		chk(e, 8'h00, "sample after reset");
		$display("test clock done");
	endtask : t_clock

	task automatic t_turn;
		wr(ultc_pkg::ADDR_TURNAROUND, 8'h03);
		wr(ultc_pkg::ADDR_FEATURE_TWO, 8'h11);
		tx_active = 1'h1;
		last_bit();
		tx_active = 1'h0;
		tick(2);
		chk({7'h00, rts_pin_n}, 8'h01, "rts high while counting");
		chk({7'h00, rx_dir}, 8'h00, "transmit direction");
		rd(ultc_pkg::ADDR_STATUS, e);
		chk({6'h00, e[1:0]}, 8'h03, "busy mid count");
		tick(1);
		@(negedge clk_sys);
		chk({7'h00, rts_pin_n}, 8'h01, "rts held at zero");
		repeat (3) @(negedge clk_sys);
		rd(ultc_pkg::ADDR_STATUS, e);
		chk({6'h00, e[1:0]}, 8'h00, "busy after count");
		chk({7'h00, rts_pin_n}, 8'h00, "rts low");
		chk({7'h00, rx_dir}, 8'h01, "receive");
		$display("test turnaround done");
	endtask : t_turn

	task automatic t_dtr;
		wr(ultc_pkg::ADDR_TURNAROUND, 8'h01);
		wr(ultc_pkg::ADDR_FEATURE_TWO, 8'h19);
		dtr_sel = 1'h1;
		tx_active = 1'h1;
		last_bit();
		tx_active = 1'h0;
		chk({6'h00, dtr_pin_n, rts_pin_n}, 8'h03, "dtr high while counting");
		tick(1);
		repeat (4) @(negedge clk_sys);
		chk({6'h00, dtr_pin_n, rts_pin_n}, 8'h01, "dtr pin");
		chk({7'h00, rx_dir}, 8'h01, "receive dtr");
		wr(ultc_pkg::ADDR_FEATURE_TWO, 8'h39);
		chk({7'h00, dtr_pin_n}, 8'h01, "inverted receive level");
		dtr_sel = 1'h0;
		$display("test dtr done");
	endtask : t_dtr

	task automatic t_off(input logic [7:0] f);
		wr(ultc_pkg::ADDR_FEATURE_TWO, f);
		chk({7'h00, nine_bit_mode}, {7'h00, f[0]}, "mode bit");
		last_bit();
		tick(1);
		repeat (4) @(negedge clk_sys);
		rd(ultc_pkg::ADDR_STATUS, e);
		chk({7'h00, e[1]}, 8'h00, "no countdown");
		chk({6'h00, dtr_pin_n, rts_pin_n}, 8'h03, "pins left alone");
		rts_modem_n = 1'h0;
		dtr_modem_n = 1'h0;
		repeat (3) @(negedge clk_sys);
		chk({6'h00, dtr_pin_n, rts_pin_n}, 8'h00, "modem values");
		rts_modem_n = 1'h1;
		dtr_modem_n = 1'h1;
		$display("test enables done");
	endtask : t_off

	// watchdog
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		print_verdict();
	end

	// main sequence
	initial
	begin
		repeat (2) @(negedge clk_sys);
		reset_n = 1'h1;
		@(negedge clk_sys);
		t_reset();
		t_levels();
		t_clock();
		t_turn();
		t_dtr();
		t_off(8'h10);
		t_off(8'h01);
		print_verdict();
	end
endmodule : tb_top
